// ---- verilog/uart_reset_defs.svh ----
// Register offsets, reset values and field positions of the UART core.
`ifndef UART_RESET_DEFS_SVH
`define UART_RESET_DEFS_SVH
`define ADR_HOLD      5'h00
`define ADR_IRQ_EN    5'h01
`define ADR_ISR_FCR   5'h02
`define ADR_LINE_CTL  5'h03
`define ADR_MODEM_CTL 5'h04
`define ADR_LINE_STAT 5'h05
`define ADR_MODEM_ST  5'h06
`define ADR_SCRATCH   5'h07
`define ADR_DIV_LOW   5'h08
`define ADR_DIV_HIGH  5'h09
`define ADR_ENH_FEAT  5'h0A
`define ADR_XTRA_FEAT 5'h0B
`define ADR_IR_WIDTH  5'h0C
`define ADR_RESUME1   5'h0D
`define ADR_RESUME2   5'h0E
`define ADR_PAUSE1    5'h0F
`define ADR_PAUSE2    5'h10
`define ADR_EVT_STAT  5'h11
`define ADR_EVT_MASK  5'h12
`define RST_ZERO      8'h00
`define RST_SCRATCH   8'hFF
`define ISR_NONE      8'h01
`define ISR_MODEM     8'h00
`define ISR_THRE      8'h02
`define LSR_IDLE      8'h60
`define ENH_BIT       4
`define MCR_IR_BIT    6
`define MCR_OUT2_BIT  3
`define ENH_IER_MASK  8'hF0
`define ENH_MCR_MASK  8'hE0
`define SUB_LAST      4'hF
`define IR_SUB_PULSE  4'h3
`define FRAME_BITS    4'hA
`endif

// ---- verilog/uart_reset_pkg.sv ----
// Types of the UART core state.
`default_nettype none
package uart_reset_pkg;
  typedef struct packed {
    logic [7:0] irq_enable;
    logic [7:0] fifo_control;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] extra_feature_control;
    logic [7:0] infrared_pulse_width;
    logic [7:0] scratch_byte;
    logic [7:0] enhanced_feature_control;
    logic [7:0] resume_char_one;
    logic [7:0] resume_char_two;
    logic [7:0] pause_char_one;
    logic [7:0] pause_char_two;
    logic [3:0] msr_delta;
    logic [3:0] modem_prev;
    logic       primed;
    logic       bus_isa;
    logic [1:0] event_status;
    logic [1:0] event_mask;
    logic [7:0] read_data;
    logic [9:0] tx_shift;
    logic [3:0] tx_bits;
    logic [3:0] tx_sub;
    logic [15:0] baud_count;
    logic       hold_full;
    logic [7:0] ir_count;
    logic       tx_line;
    logic       ir_pulse;
  } uart_state_type;
endpackage
`default_nettype wire

// ---- verilog/uart_reset_state_map.sv ----
// UART core: register file, reset state, transmitter and interrupt pins.
`include "uart_reset_defs.svh"
`default_nettype none
module uart_reset_state_map
  import uart_reset_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [4:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_strobe,
  input  wire logic       rd_strobe,
  output logic      [7:0] rdata,
  input  wire logic       isa_mode_strap,
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       ri_n,
  input  wire logic       cd_n,
  output logic            serial_tx,
  output logic            infrared_tx_out_n,
  output logic            rts_n,
  output logic            dtr_n,
  output logic            general_out_one_n,
  output logic            general_out_two_n,
  output logic            transmit_ready_n,
  output logic            receive_ready_n,
  output logic            irq_out,
  output logic            pc_request_line_a,
  output logic            pc_request_line_a_oe,
  output logic            pc_request_line_b,
  output logic            pc_request_line_b_oe,
  output logic            pc_request_line_c,
  output logic            pc_request_line_c_oe
);

  // ****************************************
  // State and helpers
  // ****************************************

  uart_state_type st;       // Registered state.
  uart_state_type next_st;  // Next state.
  logic [7:0] divisor_low_byte;   // Baud divisor, low byte.
  logic [7:0] divisor_high_byte;  // Baud divisor, high byte.
  logic [7:0] transmit_holding;   // Byte waiting to be sent.
  logic [3:0] modem_level;        // Active-high modem input levels.
  logic [7:0] modem_status;       // Modem status as read.
  logic [7:0] line_status;        // Line status as read.
  logic [7:0] irq_source_status;  // Interrupt source as read.
  logic       tx_busy;            // A frame is on the line.
  logic       baud_tick;          // Sixteen-times bit rate enable.
  logic       irq;                // Unmasked event pending.
  logic       wr_hold;            // Write to the holding byte.

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Merges a write into a register, keeping protected bits.
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] keep);
    merge = (old_v & keep) | (new_v & ~keep);
  endfunction

  // Tests an address against one offset.
  function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
    hit = (a == o);
  endfunction

  // ****************************************
  // Derived status
  // ****************************************

  // Inputs are active low; status shows them active high.
  assign modem_level = {~cd_n, ~ri_n, ~dsr_n, ~cts_n};
  assign modem_status = {modem_level, st.msr_delta};
  assign tx_busy = (st.tx_bits != 4'h0);
  assign line_status = {1'b0, ~st.hold_full & ~tx_busy, ~st.hold_full, 5'h00};
  assign wr_hold = wr_strobe & hit(addr, `ADR_HOLD);
  assign irq = |(st.event_status & st.event_mask);

  // Interrupt source: modem change first, then holding empty.
  always_comb begin
    if (st.irq_enable[3] && (st.msr_delta != 4'h0)) begin
      irq_source_status = `ISR_MODEM;
    end else if (st.irq_enable[1] && st.event_status[1]) begin
      irq_source_status = `ISR_THRE;
    end else begin
      irq_source_status = `ISR_NONE;
    end
  end

  // Baud tick: zero divisor stops the transmitter.
  assign baud_tick = ({divisor_high_byte, divisor_low_byte} != 16'h0000) &&
                     (st.baud_count == 16'h0000);

  // ****************************************
  // Unreset storage
  // ****************************************

  // Divisor and holding byte hold whatever was last written.
  // no reset on these bytes
  always_ff @(posedge core_clk) begin
    if (wr_strobe && hit(addr, `ADR_DIV_LOW)) begin
      divisor_low_byte <= wdata;
    end
    if (wr_strobe && hit(addr, `ADR_DIV_HIGH)) begin
      divisor_high_byte <= wdata;
    end
    if (wr_hold) begin
      transmit_holding <= wdata;
    end
  end

  // ****************************************
  // Next state
  // ****************************************

  always_comb begin
    logic [7:0] keep_ier;  // Protected interrupt enable bits.
    logic [7:0] keep_mcr;  // Protected modem control bits.
    logic [3:0] delta_set; // Modem input changes this cycle.
    logic [1:0] evt_set;   // Events raised this cycle.
    logic       new_bit;   // A bit period starts.
    keep_ier = 8'h00;
    keep_mcr = 8'h00;
    delta_set = 4'h0;
    evt_set = 2'b00;
    new_bit = 1'b0;
    next_st = st;
    // Enhanced bits are writable only while the enable bit is set.
    if (!st.enhanced_feature_control[`ENH_BIT]) begin
      keep_ier = `ENH_IER_MASK;
      keep_mcr = `ENH_MCR_MASK;
    end
    // Bus mode is caught once, in the first cycle after release.
    next_st.primed = 1'b1;
    if (!st.primed) begin
      next_st.bus_isa = isa_mode_strap;
    end
    // Register writes.
    if (wr_strobe) begin
      unique case (addr)
        `ADR_IRQ_EN:    next_st.irq_enable = merge(st.irq_enable, wdata, keep_ier);
        `ADR_ISR_FCR:   next_st.fifo_control = wdata;
        `ADR_LINE_CTL:  next_st.line_control = wdata;
        `ADR_MODEM_CTL: next_st.modem_control = merge(st.modem_control, wdata, keep_mcr);
        `ADR_SCRATCH:   next_st.scratch_byte = wdata;
        `ADR_ENH_FEAT:  next_st.enhanced_feature_control = wdata;
        `ADR_XTRA_FEAT: begin
          if (st.enhanced_feature_control[`ENH_BIT]) begin
            next_st.extra_feature_control = wdata;
          end
        end
        `ADR_IR_WIDTH: begin
          if (st.enhanced_feature_control[`ENH_BIT]) begin
            next_st.infrared_pulse_width = wdata;
          end
        end
        `ADR_RESUME1:   next_st.resume_char_one = wdata;
        `ADR_RESUME2:   next_st.resume_char_two = wdata;
        `ADR_PAUSE1:    next_st.pause_char_one = wdata;
        `ADR_PAUSE2:    next_st.pause_char_two = wdata;
        `ADR_EVT_MASK:  next_st.event_mask = wdata[1:0];
        default: begin
        end
      endcase
    end
    // Register reads, presented for exactly one cycle.
    next_st.read_data = 8'h00;
    if (rd_strobe) begin
      unique case (addr)
        `ADR_IRQ_EN:    next_st.read_data = st.irq_enable;
        `ADR_ISR_FCR:   next_st.read_data = irq_source_status;
        `ADR_LINE_CTL:  next_st.read_data = st.line_control;
        `ADR_MODEM_CTL: next_st.read_data = st.modem_control;
        `ADR_LINE_STAT: next_st.read_data = line_status;
        `ADR_MODEM_ST:  next_st.read_data = modem_status;
        `ADR_SCRATCH:   next_st.read_data = st.scratch_byte;
        `ADR_DIV_LOW:   next_st.read_data = divisor_low_byte;
        `ADR_DIV_HIGH:  next_st.read_data = divisor_high_byte;
        `ADR_ENH_FEAT:  next_st.read_data = st.enhanced_feature_control;
        `ADR_XTRA_FEAT: next_st.read_data = st.extra_feature_control;
        `ADR_RESUME1:   next_st.read_data = st.resume_char_one;
        `ADR_RESUME2:   next_st.read_data = st.resume_char_two;
        `ADR_PAUSE1:    next_st.read_data = st.pause_char_one;
        `ADR_PAUSE2:    next_st.read_data = st.pause_char_two;
        `ADR_EVT_STAT:  next_st.read_data = {6'h00, st.event_status};
        `ADR_EVT_MASK:  next_st.read_data = {6'h00, st.event_mask};
        default:        next_st.read_data = 8'h00;
      endcase
    end
    // Modem input change flags; a new change beats the read clear.
    next_st.modem_prev = modem_level;
    if (st.primed) begin
      delta_set = modem_level ^ st.modem_prev;
    end
    if (rd_strobe && hit(addr, `ADR_MODEM_ST)) begin
      next_st.msr_delta = 4'h0;
    end
    next_st.msr_delta = next_st.msr_delta | delta_set;
    evt_set[0] = |delta_set;
    // Holding byte accepted by the core.
    if (wr_hold) begin
      next_st.hold_full = 1'b1;
    end
    // Baud divider down-counter.
    if (baud_tick) begin
      next_st.baud_count = {divisor_high_byte, divisor_low_byte} - 16'h0001;
    end else if (st.baud_count != 16'h0000) begin
      next_st.baud_count = st.baud_count - 16'h0001;
    end
    // Frame start: start bit, eight data bits, stop bit.
    if (!tx_busy && st.hold_full) begin
      next_st.tx_shift = {1'b1, transmit_holding, 1'b0};
      next_st.tx_bits = `FRAME_BITS;
      next_st.tx_sub = 4'h0;
      next_st.hold_full = wr_hold;
      evt_set[1] = 1'b1;
      new_bit = 1'b1;
    end else if (tx_busy && baud_tick) begin
      if (st.tx_sub == `SUB_LAST) begin
        next_st.tx_sub = 4'h0;
        next_st.tx_shift = {1'b1, st.tx_shift[9:1]};
        next_st.tx_bits = st.tx_bits - 4'h1;
        new_bit = 1'b1;
      end else begin
        next_st.tx_sub = st.tx_sub + 4'h1;
      end
    end
    // Sticky events: set wins over the write-one clear.
    if (wr_strobe && hit(addr, `ADR_EVT_STAT)) begin
      next_st.event_status = st.event_status & ~wdata[1:0];
    end
    next_st.event_status = next_st.event_status | evt_set;
    // Programmed pulse width counts core clocks from bit start.
    if (new_bit) begin
      next_st.ir_count = st.infrared_pulse_width;
    end else if (st.ir_count != 8'h00) begin
      next_st.ir_count = st.ir_count - 8'h01;
    end
    // Line level: idle mark between frames and in infrared mode.
    // mark level when idle
    next_st.tx_line = 1'b1;
    if (next_st.tx_bits != 4'h0 && !st.modem_control[`MCR_IR_BIT]) begin
      next_st.tx_line = next_st.tx_shift[0];
    end
    // Infrared: pulse only on zero bits while a frame runs.
    // 3/16 pulse at zero width
    next_st.ir_pulse = 1'b0;
    if (st.modem_control[`MCR_IR_BIT] && next_st.tx_bits != 4'h0 && !next_st.tx_shift[0]) begin
      if (st.infrared_pulse_width == 8'h00) begin
        next_st.ir_pulse = (next_st.tx_sub < `IR_SUB_PULSE);
      end else begin
        next_st.ir_pulse = (next_st.ir_count != 8'h00);
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************

  // Reset loads the power-on register values.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.scratch_byte <= `RST_SCRATCH;
      st.tx_line <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  assign rdata = st.read_data;
  assign serial_tx = st.tx_line;
  assign infrared_tx_out_n = st.ir_pulse;
  assign dtr_n = ~st.modem_control[0];
  assign rts_n = ~st.modem_control[1];
  assign general_out_one_n = ~st.modem_control[2];
  assign general_out_two_n = ~st.modem_control[3];
  assign transmit_ready_n = st.hold_full;
  assign receive_ready_n = 1'b1;
  assign irq_out = ~st.bus_isa & irq;
  // request lines driven only when gated on
  assign pc_request_line_a = irq;
  assign pc_request_line_b = irq;
  assign pc_request_line_c = irq;
  assign pc_request_line_a_oe = st.bus_isa & st.modem_control[`MCR_OUT2_BIT] &
                                (st.extra_feature_control[1:0] == 2'd0);
  assign pc_request_line_b_oe = st.bus_isa & st.modem_control[`MCR_OUT2_BIT] &
                                (st.extra_feature_control[1:0] == 2'd1);
  assign pc_request_line_c_oe = st.bus_isa & st.modem_control[`MCR_OUT2_BIT] &
                                st.extra_feature_control[1];

  // ****************************************
  // Checks
  // ****************************************

  sequence s_write_char;
    wr_strobe && hit(addr, `ADR_PAUSE2);
  endsequence
  sequence s_read_char;
    rd_strobe && hit(addr, `ADR_PAUSE2) && !wr_strobe;
  endsequence

  a_char_round_trip: assert property (
    s_write_char ##1 s_read_char |=> rdata == $past(wdata, 2))
    else $error("flow character not returned");
  a_chars_cleared: assert property (
    $past(reset) |-> {st.resume_char_one, st.resume_char_two,
                      st.pause_char_one, st.pause_char_two} == 32'h0)
    else $error("flow characters not zero after reset");
  a_controls_cleared: assert property (
    $past(reset) |-> {st.irq_enable, st.fifo_control,
                      st.line_control, st.modem_control} == 32'h0)
    else $error("control registers not zero after reset");
  a_isr_idle: assert property (
    $past(reset) |-> irq_source_status == 8'h01)
    else $error("interrupt status not 0x01 after reset");
  a_lsr_idle: assert property (
    $past(reset) |-> line_status == 8'h60)
    else $error("line status not 0x60 after reset");
  a_msr_levels: assert property (
    $past(reset) |-> st.msr_delta == 4'h0 && modem_status[7:4] == ~{cd_n, ri_n, dsr_n, cts_n})
    else $error("modem status wrong after reset");
  a_scratch_ones: assert property (
    $past(reset) |-> st.scratch_byte == 8'hFF && st.enhanced_feature_control == 8'h00)
    else $error("scratch or enhanced register wrong after reset");
  a_line_idle: assert property (
    !tx_busy && !$past(tx_busy) |-> serial_tx)
    else $error("serial line not at mark while idle");
  a_ir_quiet: assert property (
    !st.modem_control[`MCR_IR_BIT] [*2] |-> !infrared_tx_out_n)
    else $error("infrared output active outside infrared mode");
  a_modem_outs: assert property (
    $past(reset) |-> rts_n && dtr_n && general_out_one_n && general_out_two_n && !transmit_ready_n)
    else $error("modem outputs not idle after reset");

endmodule
`default_nettype wire

// ---- sim/uart_line_partner.sv ----
// Far-side model of the serial line and the modem input pins.
`default_nettype none
module uart_line_partner (
  input  wire logic       core_clk,
  input  wire logic       serial_tx,
  input  wire logic       infrared_tx_out_n,
  input  wire logic [3:0] modem_level_n,
  output logic            cts_n,
  output logic            dsr_n,
  output logic            ri_n,
  output logic            cd_n,
  output logic [7:0]      rx_byte,
  output logic            rx_stop,
  output int              rx_count,
  output int              ir_width,
  output int              ir_pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Modem pins and serial receiver
  // ****************************************
  localparam int BIT_CLOCKS = 16; // Clocks per bit with a divisor of one.
  int run;                        // Length of the infrared pulse in progress.
  // The modem pins follow the level vector that the bench sets, carrier detect in bit 3, clear-to-send in bit 0.
  assign {cd_n, ri_n, dsr_n, cts_n} = modem_level_n;
  // The receiver samples mid-bit after a start edge, LSB first, then the stop bit.
  initial begin
    rx_count = 0;
    rx_byte = 8'h00;
    rx_stop = 1'b0;
    forever begin
      @(negedge serial_tx);
      repeat (BIT_CLOCKS / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLOCKS) @(posedge core_clk);
        rx_byte[i] = serial_tx;
      end
      repeat (BIT_CLOCKS) @(posedge core_clk);
      rx_stop = serial_tx;
      rx_count++;
    end
  end
  // The emitter watcher measures each infrared pulse in clocks and counts them.
  always @(posedge core_clk) begin
    if (infrared_tx_out_n === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      ir_width <= run;
      ir_pulses <= ir_pulses + 1;
      run <= 0;
    end
  end
endmodule
`default_nettype wire

// ---- sim/tb_uart_reset_state_map.sv ----
// Self-checking bench for the UART reset state and register file.
`include "uart_reset_defs.svh"
`default_nettype none
module tb_uart_reset_state_map;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic       core_clk, reset, wr_strobe, rd_strobe, isa_mode_strap;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, rx_byte;
  logic [3:0] modem_level_n;
  logic       cts_n, dsr_n, ri_n, cd_n, serial_tx, infrared_tx_out_n, rts_n, dtr_n, rx_stop;
  logic       general_out_one_n, general_out_two_n, transmit_ready_n, receive_ready_n, irq_out;
  logic       qa, qa_oe, qb, qb_oe, qc, qc_oe;
  int         rx_count, ir_width, ir_pulses, err_total, checks, cycles;
  uart_reset_state_map uart_reset_state_map_inst (.core_clk(core_clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
    .isa_mode_strap(isa_mode_strap), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n),
    .serial_tx(serial_tx), .infrared_tx_out_n(infrared_tx_out_n), .rts_n(rts_n), .dtr_n(dtr_n),
    .general_out_one_n(general_out_one_n), .general_out_two_n(general_out_two_n),
    .transmit_ready_n(transmit_ready_n), .receive_ready_n(receive_ready_n), .irq_out(irq_out),
    .pc_request_line_a(qa), .pc_request_line_a_oe(qa_oe), .pc_request_line_b(qb),
    .pc_request_line_b_oe(qb_oe), .pc_request_line_c(qc), .pc_request_line_c_oe(qc_oe));
  uart_line_partner uart_line_partner_inst (.core_clk(core_clk), .serial_tx(serial_tx),
    .infrared_tx_out_n(infrared_tx_out_n), .modem_level_n(modem_level_n), .cts_n(cts_n),
    .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .rx_byte(rx_byte), .rx_stop(rx_stop),
    .rx_count(rx_count), .ir_width(ir_width), .ir_pulses(ir_pulses));
  // ****************************************
  // Shared tasks
  // ****************************************
  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle write strobe beside address and data.
  task automatic bus_write(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge core_clk);
    wr_strobe <= 1'b0;
  endtask
  // One-cycle read strobe; the data stand only in the following cycle.
  task automatic read_chk(input string what, input logic [4:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge core_clk);
    rd_strobe <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask
  // Checks every output pin except the request lines and read data against its reset level.
  task automatic pin_chk();
    chk("pins", 8'hBD, {serial_tx, infrared_tx_out_n, rts_n, dtr_n, general_out_one_n,
      general_out_two_n, transmit_ready_n, receive_ready_n});
    chk("irq_pins", 8'h00, {4'h0, irq_out, qa_oe, qb_oe, qc_oe});
  endtask
  // Holds reset for nine cycles with the given strap and checks the pins on both sides.
  task automatic apply_reset(input logic isa);
    @(posedge core_clk);
    reset <= 1'b1;
    isa_mode_strap <= isa;
    repeat (8) @(posedge core_clk);
    #1;
    pin_chk();
    @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    pin_chk();
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Reads every readable register but the divisor and event bytes, and an unmapped offset, against the reset table.
  task automatic test_reset_regs();
    logic [4:0] ra [13] = '{`ADR_IRQ_EN, `ADR_LINE_CTL, `ADR_MODEM_CTL, `ADR_ISR_FCR, `ADR_LINE_STAT,
      `ADR_MODEM_ST, `ADR_SCRATCH, `ADR_ENH_FEAT, `ADR_XTRA_FEAT, `ADR_RESUME1, `ADR_RESUME2,
      `ADR_PAUSE1, 5'h1F};
    logic [7:0] rv [13] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h60, 8'h90, 8'hFF, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 13; i++) begin
      read_chk("reset_register", ra[i], rv[i]);
    end
    read_chk("pause_char_two", `ADR_PAUSE2, 8'h00);
  endtask
  // Writes the four characters and scratch with an idle cycle between writes, reads them, then resets mid-run.
  task automatic test_char_rw();
    for (int i = 0; i < 4; i++) begin
      bus_write(5'(`ADR_RESUME1 + i), 8'(8'h11 * (i + 1)));
    end
    bus_write(`ADR_SCRATCH, 8'h3C);
    bus_write(`ADR_XTRA_FEAT, 8'h5A);
    for (int i = 0; i < 4; i++) begin
      read_chk("flow_char", 5'(`ADR_RESUME1 + i), 8'(8'h11 * (i + 1)));
    end
    read_chk("scratch_byte", `ADR_SCRATCH, 8'h3C);
    read_chk("extra_feature_control", `ADR_XTRA_FEAT, 8'h00);
    // A write followed at once by a read of the same character register.
    @(posedge core_clk);
    addr <= `ADR_PAUSE2;
    wdata <= 8'h6B;
    wr_strobe <= 1'b1;
    @(posedge core_clk);
    wr_strobe <= 1'b0;
    rd_strobe <= 1'b1;
    @(posedge core_clk);
    rd_strobe <= 1'b0;
    #1;
    chk("back_to_back", 8'h6B, rdata);
    apply_reset(1'b0);
    test_reset_regs();
  endtask
  // Drives the modem control bits and checks the inverted output pins.
  task automatic test_modem_out();
    bus_write(`ADR_MODEM_CTL, 8'h05);
    @(posedge core_clk);
    #1;
    chk("modem_out", 8'h09, {4'h0, rts_n, dtr_n, general_out_one_n, general_out_two_n});
    bus_write(`ADR_MODEM_CTL, 8'h00);
  endtask
  // Toggles the clear-to-send pin and follows status, change bit and interrupt.
  task automatic test_modem_irq();
    logic irq_a;
    bus_write(`ADR_EVT_STAT, 8'h03);
    modem_level_n <= 4'b0111;
    repeat (4) @(posedge core_clk);
    read_chk("modem_status", `ADR_MODEM_ST, 8'h81);
    read_chk("modem_status", `ADR_MODEM_ST, 8'h80);
    read_chk("event_status", `ADR_EVT_STAT, 8'h01);
    bus_write(`ADR_EVT_MASK, 8'h00);
    #1;
    irq_a = irq_out;
    bus_write(`ADR_EVT_MASK, 8'h03);
    #1;
    chk("irq_mask_effect", 8'h01, {7'h00, irq_a ^ irq_out});
    bus_write(`ADR_EVT_STAT, 8'h01);
    read_chk("event_status", `ADR_EVT_STAT, 8'h00);
    chk("irq_cleared", 8'h00, {7'h00, irq_out});
  endtask
  // Sends one byte at divisor one and lets the partner decode it.
  task automatic test_transmit();
    int n;
    n = rx_count;
    bus_write(`ADR_DIV_LOW, 8'h01);
    bus_write(`ADR_DIV_HIGH, 8'h00);
    bus_write(`ADR_HOLD, 8'hA5);
    for (int i = 0; i < 400 && rx_count == n; i++) @(posedge core_clk);
    chk("rx_byte", 8'hA5, rx_byte);
    chk("stop_bit", 8'h01, {7'h00, rx_stop});
  endtask
  // Sends a zero byte in infrared mode and measures the emitter pulses, then resets mid-frame.
  task automatic test_infrared();
    int p;
    int lows;
    lows = 0;
    p = ir_pulses;
    bus_write(`ADR_ENH_FEAT, 8'h10);
    bus_write(`ADR_MODEM_CTL, 8'h40);
    bus_write(`ADR_HOLD, 8'h00);
    repeat (300) begin
      @(posedge core_clk);
      lows += (serial_tx !== 1'b1);
    end
    chk("ir_pulses", 8'd9, 8'(ir_pulses - p));
    chk("ir_width", 8'd3, 8'(ir_width));
    chk("serial_lows", 8'h00, 8'(lows));
    bus_write(`ADR_HOLD, 8'h00);
    repeat (20) @(posedge core_clk);
    apply_reset(1'b0);
  endtask
  // In ISA bus mode, steers the request lines by their enables and raises them on a modem event.
  task automatic test_isa_lines();
    bus_write(`ADR_MODEM_CTL, 8'h08);
    #1;
    chk("isa_line_a", 8'h04, {4'h0, irq_out, qa_oe, qb_oe, qc_oe});
    bus_write(`ADR_ENH_FEAT, 8'h10);
    bus_write(`ADR_XTRA_FEAT, 8'h02);
    #1;
    chk("isa_line_c", 8'h01, {4'h0, irq_out, qa_oe, qb_oe, qc_oe});
    bus_write(`ADR_EVT_MASK, 8'h01);
    modem_level_n <= 4'b0110;
    repeat (2) @(posedge core_clk);
    #1;
    chk("isa_lines", 8'h07, {4'h0, irq_out, qa, qb, qc});
  endtask
  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  // Ends the run with the counts and the verdict.
  task automatic complete_run();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // The clock runs at 25 MHz.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // A hang is cut short after a fixed number of cycles.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // Sets every input at time zero and runs the scenarios in order.
  initial begin
    {wr_strobe, rd_strobe, isa_mode_strap, addr, wdata} = '0;
    reset = 1'b1;
    modem_level_n = 4'b0110;
    {err_total, checks, cycles} = '0;
    apply_reset(1'b0);
    test_reset_regs();
    test_char_rw();
    test_modem_out();
    test_modem_irq();
    test_transmit();
    test_infrared();
    apply_reset(1'b1);
    test_isa_lines();
    complete_run();
  end
endmodule
`default_nettype wire
